// [ilx_exec.sv]
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ilx_map.svh"

module ilx_exec (
	input wire logic ref_clk,
	input wire logic reset,
	input wire ilx_pkg::ilx_issue_t issue_in,
	output logic issue_go,
	output logic [1:0] issue_len,
	output logic op_foreign,
	input wire logic cm_read_range_err,
	input wire logic cm_write_range_err,
	input wire logic float_range_err,
	output ilx_pkg::ilx_awb_t a_wb,
	output ilx_pkg::ilx_swb_t s_wb,
	output ilx_pkg::ilx_lmwb_t lm_wb,
	output logic [31:0] status_word,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	////////////////////////////////////////////////////////////////////////
	// Phase to cycle conversion
	// Free by a phase: round down, the resource must already be free
	function automatic logic [4:0] by_ph(input int ph);
		return 5'(ph / `PHASES_PER_CYCLE);
	endfunction : by_ph

	// Busy until a phase: round up so the resource is never released early
	function automatic logic [4:0] hold_ph(input int ph);
		return 5'((ph + `PHASES_PER_CYCLE - 1) / `PHASES_PER_CYCLE);
	endfunction : hold_ph

	// Cycles to wait before the next issue; phase 2 means back to back
	function automatic logic [4:0] next_ph(input int ph);
		return 5'(ph / `PHASES_PER_CYCLE - 1);
	endfunction : next_ph

	////////////////////////////////////////////////////////////////////////
	// State
	logic [31:0] a_q [8];
	logic [63:0] s_q [8];
	logic [63:0] lm_mem [2**`LM_AW];
	logic [4:0] a_busy_q [8];
	logic [4:0] s_busy_q [8];
	logic [4:0] lm_busy_q;
	logic [4:0] ap_busy_q;
	logic [4:0] sp_busy_q;
	logic [4:0] next_wait_q;
	logic cm_rd_err_q;
	logic cm_wr_err_q;
	logic cm_int_en_q;
	logic fp_err_q;
	logic fp_test_en_q;
	logic issue_hold_q;
	logic [31:0] issue_cnt_q;

	// Decode
	logic [6:0] op;
	logic [2:0] fi;
	logic [2:0] fj;
	logic [2:0] fk;
	logic known;
	logic ready;
	logic [1:0] need_par;
	logic [4:0] set_a;
	logic [4:0] set_s;
	logic [4:0] set_lm;
	logic [4:0] set_ap;
	logic [4:0] set_sp;
	logic [4:0] next_val;
	logic [`LM_AW-1:0] lm_addr;
	logic [63:0] lm_rd;

	assign op = issue_in.parcel[15:9];
	assign fi = issue_in.parcel[8:6];
	assign fj = issue_in.parcel[5:3];
	assign fk = issue_in.parcel[2:0];

	////////////////////////////////////////////////////////////////////////
	// Issue conditions and reservations per opcode
	always_comb begin
		known = 1'b1;
		ready = 1'b1;
		need_par = 2'd0;
		set_a = '0;
		set_s = '0;
		set_lm = '0;
		set_ap = '0;
		set_sp = '0;
		next_val = '0;
		case (op)
			`OP_RANGE_CTL: begin
				next_val = next_ph(`PH_RANGE_NEXT); // No issue conditions at all
			end
			`OP_A_IMM16_Z, `OP_A_IMM16_O: begin
				need_par = 2'd1;
				ready = (a_busy_q[fi] <= by_ph(`PH_A_SRC_FREE)) && (ap_busy_q <= by_ph(`PH_IMM16_PATH));
				next_val = next_ph(`PH_IMM16_NEXT);
				set_a = hold_ph(`PH_IMM16_DONE);
				set_ap = hold_ph(`PH_IMM16_DONE);
			end
			`OP_A_IMM32, `OP_A_IMM32_ALT: begin
				need_par = 2'd2;
				ready = (a_busy_q[fi] <= by_ph(`PH_A_SRC_FREE)) && (ap_busy_q <= by_ph(`PH_IMM32_PATH));
				next_val = next_ph(`PH_IMM32_NEXT);
				set_a = hold_ph(`PH_IMM32_DONE);
				set_ap = hold_ph(`PH_IMM32_DONE);
			end
			`OP_A_LM_RD_DIR: begin
				need_par = 2'd1;
				ready = (a_busy_q[fi] <= by_ph(`PH_A_SRC_FREE)) && (lm_busy_q <= by_ph(`PH_LM_REQ)) &&
					(ap_busy_q <= by_ph(`PH_LMRD_PATH));
				next_val = next_ph(`PH_DIR_NEXT);
				set_a = hold_ph(`PH_LMRD_DEST_DONE);
				set_lm = hold_ph(`PH_DIR_LM_DONE);
				set_ap = hold_ph(`PH_LMRD_DEST_DONE);
			end
			`OP_A_LM_WR_DIR: begin
				need_par = 2'd1;
				ready = (a_busy_q[fj] <= by_ph(`PH_A_SRC_FREE)) && (lm_busy_q <= by_ph(`PH_LM_REQ));
				next_val = next_ph(`PH_DIR_NEXT);
				set_lm = hold_ph(`PH_DIR_LM_DONE);
			end
			`OP_A_LM_RD_IND: begin
				ready = (a_busy_q[fk] <= by_ph(`PH_A_SRC_FREE)) && (a_busy_q[fi] <= by_ph(`PH_A_SRC_FREE)) &&
					(lm_busy_q <= by_ph(`PH_LM_REQ)) && (ap_busy_q <= by_ph(`PH_LMRD_PATH));
				next_val = next_ph(`PH_IND_NEXT);
				set_lm = hold_ph(`PH_IND_LM_DONE);
				set_a = hold_ph(`PH_LMRD_DEST_DONE);
				set_ap = hold_ph(`PH_LMRD_DEST_DONE);
			end
			`OP_A_LM_WR_IND: begin
				ready = (a_busy_q[fj] <= by_ph(`PH_A_SRC_FREE)) && (a_busy_q[fk] <= by_ph(`PH_A_SRC_FREE)) &&
					(lm_busy_q <= by_ph(`PH_LM_REQ));
				next_val = next_ph(`PH_IND_NEXT);
				set_lm = hold_ph(`PH_IND_LM_DONE);
			end
			`OP_S_LO_Z, `OP_S_LO_O, `OP_S_HI_Z: begin
				need_par = 2'd2;
				ready = (s_busy_q[fi] <= by_ph(`PH_S_DEST_FREE)) && (sp_busy_q <= by_ph(`PH_SHALF_PATH));
				next_val = next_ph(`PH_SHALF_NEXT);
				set_s = hold_ph(`PH_SHALF_DONE);
				set_sp = hold_ph(`PH_SHALF_DONE);
			end
			default: begin
				known = 1'b0;
				ready = 1'b0;
			end
		endcase
	end

	// Hold the instruction until all resources and parcels line up
	assign issue_go = issue_in.valid && known && ready && !issue_hold_q && (next_wait_q == 5'd0) &&
		(issue_in.follow_cnt >= need_par);
	assign issue_len = issue_go ? need_par + 2'd1 : 2'd0;
	// Opcodes outside this group are left for other decoders
	assign op_foreign = issue_in.valid && !known;

	////////////////////////////////////////////////////////////////////////
	// Reservation counters: load on issue, count down otherwise
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int n = 0; n < 8; n++) begin
				a_busy_q[n] <= '0;
				s_busy_q[n] <= '0;
			end
			lm_busy_q <= '0;
			ap_busy_q <= '0;
			sp_busy_q <= '0;
			next_wait_q <= '0;
		end else begin
			for (int n = 0; n < 8; n++) begin
				if (issue_go && set_a != 5'd0 && fi == 3'(n)) begin
					a_busy_q[n] <= set_a - 5'd1;
				end else if (a_busy_q[n] != 5'd0) begin
					a_busy_q[n] <= a_busy_q[n] - 5'd1;
				end
				if (issue_go && set_s != 5'd0 && fi == 3'(n)) begin
					s_busy_q[n] <= set_s - 5'd1;
				end else if (s_busy_q[n] != 5'd0) begin
					s_busy_q[n] <= s_busy_q[n] - 5'd1;
				end
			end
			if (issue_go && set_lm != 5'd0) begin
				lm_busy_q <= set_lm - 5'd1;
			end else if (lm_busy_q != 5'd0) begin
				lm_busy_q <= lm_busy_q - 5'd1;
			end
			if (issue_go && set_ap != 5'd0) begin
				ap_busy_q <= set_ap - 5'd1;
			end else if (ap_busy_q != 5'd0) begin
				ap_busy_q <= ap_busy_q - 5'd1;
			end
			if (issue_go && set_sp != 5'd0) begin
				sp_busy_q <= set_sp - 5'd1;
			end else if (sp_busy_q != 5'd0) begin
				sp_busy_q <= sp_busy_q - 5'd1;
			end
			if (issue_go) begin
				next_wait_q <= next_val;
			end else if (next_wait_q != 5'd0) begin
				next_wait_q <= next_wait_q - 5'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Local memory: direct address from next parcel, indirect from a register
	always_comb begin
		case (op)
			`OP_A_LM_RD_IND: lm_addr = a_q[fk][`LM_AW-1:0];
			`OP_A_LM_WR_IND: lm_addr = a_q[fk][`LM_AW-1:0];
			default: lm_addr = issue_in.next1[`LM_AW-1:0];
		endcase
	end
	assign lm_rd = lm_mem[lm_addr];

	// Memory array is not reset; contents are undefined until written
	always_ff @(posedge ref_clk) begin
		if (issue_go && (op == `OP_A_LM_WR_DIR)) begin
			lm_mem[lm_addr] <= {{32{a_q[fj][31]}}, a_q[fj]};
		end else if (issue_go && (op == `OP_A_LM_WR_IND)) begin
			lm_mem[lm_addr] <= {{32{a_q[fj][31]}}, a_q[fj]};
		end
	end

	// Local memory write report
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lm_wb <= '0;
		end else begin
			lm_wb.valid <= issue_go && (op == `OP_A_LM_WR_DIR || op == `OP_A_LM_WR_IND);
			lm_wb.addr <= lm_addr;
			lm_wb.data <= {{32{a_q[fj][31]}}, a_q[fj]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address register file and its write-back report
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int n = 0; n < 8; n++) begin
				a_q[n] <= '0;
			end
			a_wb <= '0;
		end else begin
			a_wb.valid <= 1'b0;
			if (issue_go && set_a != 5'd0) begin
				a_wb.valid <= 1'b1;
				a_wb.idx <= fi;
				case (op)
					`OP_A_IMM16_Z: begin
						a_q[fi] <= {16'h0000, issue_in.next1};
						a_wb.data <= {16'h0000, issue_in.next1};
					end
					`OP_A_IMM16_O: begin
						a_q[fi] <= {16'hFFFF, issue_in.next1};
						a_wb.data <= {16'hFFFF, issue_in.next1};
					end
					`OP_A_IMM32, `OP_A_IMM32_ALT: begin
						a_q[fi] <= {issue_in.next1, issue_in.next2};
						a_wb.data <= {issue_in.next1, issue_in.next2};
					end
					default: begin
						a_q[fi] <= lm_rd[31:0];
						a_wb.data <= lm_rd[31:0];
					end
				endcase
			end
		end
	end

	// Scalar register file; first following parcel is the more significant
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int n = 0; n < 8; n++) begin
				s_q[n] <= '0;
			end
			s_wb <= '0;
		end else begin
			s_wb.valid <= 1'b0;
			if (issue_go && set_s != 5'd0) begin
				s_wb.valid <= 1'b1;
				s_wb.idx <= fi;
				case (op)
					`OP_S_LO_O: begin
						s_q[fi] <= {32'hFFFF_FFFF, issue_in.next1, issue_in.next2};
						s_wb.data <= {32'hFFFF_FFFF, issue_in.next1, issue_in.next2};
					end
					`OP_S_HI_Z: begin
						s_q[fi] <= {issue_in.next1, issue_in.next2, 32'h0000_0000};
						s_wb.data <= {issue_in.next1, issue_in.next2, 32'h0000_0000};
					end
					default: begin
						s_q[fi] <= {32'h0000_0000, issue_in.next1, issue_in.next2};
						s_wb.data <= {32'h0000_0000, issue_in.next1, issue_in.next2};
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus write channel signals
	logic aw_hold_q;
	logic w_hold_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire;
	logic sw_clr_rd;
	logic sw_clr_wr;
	logic sw_clr_fp;
	logic range_ctl;

	assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
	// Software write-one-to-clear of error flags in the status word
	assign sw_clr_rd = wr_fire && awaddr_q == `REG_STATUS && wstrb_q[1] && wdata_q[`ST_CM_RD_ERR];
	assign sw_clr_wr = wr_fire && awaddr_q == `REG_STATUS && wstrb_q[1] && wdata_q[`ST_CM_WR_ERR];
	assign sw_clr_fp = wr_fire && awaddr_q == `REG_STATUS && wstrb_q[2] && wdata_q[`ST_FP_ERR];
	assign range_ctl = issue_go && (op == `OP_RANGE_CTL);

	////////////////////////////////////////////////////////////////////////
	// Status flags; an arriving error beats a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cm_rd_err_q <= 1'b0;
			cm_wr_err_q <= 1'b0;
			fp_err_q <= 1'b0;
		end else begin
			cm_rd_err_q <= (cm_rd_err_q && !sw_clr_rd && !(range_ctl && fk == `K_EN_MEM_RANGE_INT)) ||
				cm_read_range_err;
			cm_wr_err_q <= (cm_wr_err_q && !sw_clr_wr && !(range_ctl && fk == `K_EN_MEM_RANGE_INT)) ||
				cm_write_range_err;
			fp_err_q <= (fp_err_q && !sw_clr_fp) || float_range_err;
		end
	end

	// Range-control designators 0..3 in order; 4..7 change nothing
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cm_int_en_q <= `RST_CM_INT_EN;
			fp_test_en_q <= `RST_FP_TEST_EN;
		end else if (range_ctl) begin
			case (fk)
				`K_DIS_MEM_RANGE_INT: cm_int_en_q <= 1'b0;
				`K_EN_MEM_RANGE_INT: cm_int_en_q <= 1'b1;
				`K_DIS_FLOAT_TESTS: fp_test_en_q <= 1'b0;
				`K_EN_FLOAT_TESTS: fp_test_en_q <= 1'b1;
				default: cm_int_en_q <= cm_int_en_q;
			endcase
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`ST_CM_RD_ERR] = cm_rd_err_q;
		status_word[`ST_CM_WR_ERR] = cm_wr_err_q;
		status_word[`ST_CM_INT_EN] = cm_int_en_q;
		status_word[`ST_FP_ERR] = fp_err_q;
		status_word[`ST_FP_TEST_EN] = fp_test_en_q;
	end

	// Issue counter, visible to software for progress checks
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			issue_cnt_q <= '0;
		end else if (issue_go) begin
			issue_cnt_q <= issue_cnt_q + 32'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave write side: address and data taken in either order
	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_q && !s_axi_bvalid;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[31:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == `REG_STATUS || awaddr_q == `REG_CTRL ||
					awaddr_q == `REG_ISSUE_CNT) ? `AXI_OKAY : `AXI_DECERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register: bit 0 freezes issue, useful to single-step software
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			issue_hold_q <= `RST_ISSUE_HOLD;
		end else if (wr_fire && awaddr_q == `REG_CTRL && wstrb_q[0]) begin
			issue_hold_q <= wdata_q[0];
		end
	end

	// Bus slave read side: one outstanding read
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `AXI_OKAY;
			case ({s_axi_araddr[31:2], 2'b00})
				`REG_STATUS: s_axi_rdata <= status_word;
				`REG_CTRL: s_axi_rdata <= {31'd0, issue_hold_q};
				`REG_ISSUE_CNT: s_axi_rdata <= issue_cnt_q;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `AXI_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : ilx_exec

// [ilx_map.svh]
// How it works
// - Range-control with designator 0 clears the memory range interrupt enable, bit 15.
// - Designator 1 clears read and write range flags 13, 14 and sets bit 15.
// - Designator 2 clears float range test enable bit 18; designator 3 sets it.
// - Every memory and float range error is recorded, enabled or not.
// - Range-control waits on no resource, only on the issue hold and the previous next-issue count; next issue at phase 20.
// - Opcode 040 loads address register with next parcel, upper 16 bits zero.
// - Opcode 041 loads address register with next parcel, upper 16 bits ones.
// - Opcodes 042 and 043 both load a 32-bit constant from two parcels.
// - 32-bit load needs path by 8 and two parcels; next 6, free 9.
// - Direct local read: address in next parcel, low 32 bits delivered.
// - Direct read needs memory by 9, path by 20; next 4, frees 21.
// - Direct local write stores sign-extended register; next 4, memory frees 21.
// - Indirect local read addressed by register; next 2, memory 19, destination 21.
// - Indirect local write stores sign-extended register; sources by 3, memory frees 19.
// - Opcode 050 loads scalar low half from two parcels, upper half zero.
// - Opcode 051 loads scalar low half from two parcels, upper half ones.
// - Opcode 052 loads scalar upper half from two parcels, lower half zero.
// - Scalar half loads need register by 5, path by 10; next 6, free 11.
// - Phases are half clock periods, two to a cycle.
// - Designators 0 to 3 map to the four range-control actions in order.
`ifndef ILX_MAP_SVH
`define ILX_MAP_SVH

// Time base: one phase is half a clock period
`define CLK_PERIOD_NS 10
`define PHASES_PER_CYCLE 2

// Opcodes (octal)
`define OP_RANGE_CTL 7'o37
`define OP_A_IMM16_Z 7'o40
`define OP_A_IMM16_O 7'o41
`define OP_A_IMM32 7'o42
`define OP_A_IMM32_ALT 7'o43
`define OP_A_LM_RD_DIR 7'o44
`define OP_A_LM_WR_DIR 7'o45
`define OP_A_LM_RD_IND 7'o46
`define OP_A_LM_WR_IND 7'o47
`define OP_S_LO_Z 7'o50
`define OP_S_LO_O 7'o51
`define OP_S_HI_Z 7'o52

// Range-control designators
`define K_DIS_MEM_RANGE_INT 3'd0
`define K_EN_MEM_RANGE_INT 3'd1
`define K_DIS_FLOAT_TESTS 3'd2
`define K_EN_FLOAT_TESTS 3'd3

// Phase figures
`define PH_RANGE_NEXT 20
`define PH_A_SRC_FREE 3
`define PH_S_DEST_FREE 5
`define PH_LM_REQ 9
`define PH_IMM16_PATH 6
`define PH_IMM16_NEXT 4
`define PH_IMM16_DONE 7
`define PH_IMM32_PATH 8
`define PH_IMM32_NEXT 6
`define PH_IMM32_DONE 9
`define PH_LMRD_PATH 20
`define PH_DIR_NEXT 4
`define PH_DIR_LM_DONE 21
`define PH_IND_NEXT 2
`define PH_IND_LM_DONE 19
`define PH_LMRD_DEST_DONE 21
`define PH_SHALF_PATH 10
`define PH_SHALF_NEXT 6
`define PH_SHALF_DONE 11

// Status bit positions
`define ST_CM_RD_ERR 13
`define ST_CM_WR_ERR 14
`define ST_CM_INT_EN 15
`define ST_FP_ERR 16
`define ST_FP_TEST_EN 18

// Reset values
`define RST_CM_INT_EN 1'b0
`define RST_FP_TEST_EN 1'b0
`define RST_ISSUE_HOLD 1'b0

// Local memory address width
`define LM_AW 10

// Register bus map
`define REG_STATUS 32'h0000_0000
`define REG_CTRL 32'h0000_0004
`define REG_ISSUE_CNT 32'h0000_0008
`define AXI_OKAY 2'b00
`define AXI_DECERR 2'b11

`endif

// [ilx_pkg.sv]
package ilx_pkg;

	// Instruction at the head of the issue queue plus its following parcels
	typedef struct packed {
		logic valid;
		logic [15:0] parcel;
		logic [15:0] next1;
		logic [15:0] next2;
		logic [1:0] follow_cnt;
	} ilx_issue_t;

	// Address register write-back report
	typedef struct packed {
		logic valid;
		logic [2:0] idx;
		logic [31:0] data;
	} ilx_awb_t;

	// Scalar register write-back report
	typedef struct packed {
		logic valid;
		logic [2:0] idx;
		logic [63:0] data;
	} ilx_swb_t;

	// Local memory write report
	typedef struct packed {
		logic valid;
		logic [9:0] addr;
		logic [63:0] data;
	} ilx_lmwb_t;

endpackage : ilx_pkg

// [ilx_exec_properties.sv]
`timescale 1ns/1ps
module ilx_exec_properties (
	input wire logic ref_clk,
	input wire logic reset,
	input wire ilx_pkg::ilx_issue_t issue_in,
	input wire logic issue_go,
	input wire logic [1:0] issue_len,
	input wire logic cm_read_range_err,
	input wire logic cm_write_range_err,
	input wire ilx_pkg::ilx_awb_t a_wb,
	input wire ilx_pkg::ilx_swb_t s_wb,
	input wire ilx_pkg::ilx_lmwb_t lm_wb,
	input wire logic [31:0] status_word
);
	logic [6:0] op;
	logic [2:0] kd;
	// Head opcode and designator
	assign op = issue_in.parcel[15:9];
	assign kd = issue_in.parcel[2:0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// Issue of one opcode, and the quiet span after range control
	sequence go_op(o);
		issue_go && op == o;
	endsequence
	sequence quiet9;
		!issue_go [*8] ##1 !issue_go;
	endsequence
	a_range_quiet: assert property (go_op(7'o37) |=> quiet9) else $error("issue in range gap");
	a_range_on: assert property (issue_go && op == 7'o37 && kd == 3'd1 && !cm_read_range_err
		&& !cm_write_range_err |=> status_word[15:13] == 3'b100) else $error("bad k1 status");
	a_float_test: assert property (issue_go && op == 7'o37 && kd[2:1] == 2'b01
		|=> status_word[18] == $past(kd[0])) else $error("bad bit 18");
	a_err_record: assert property (cm_read_range_err |=> status_word[13]) else $error("error lost");
	a_imm16_fill: assert property (issue_go && op inside {7'o40, 7'o41} |=> a_wb.valid && !issue_go
		&& a_wb.data == {{16{$past(op[0])}}, $past(issue_in.next1)}) else $error("bad 16 bit load");
	a_imm32_join: assert property (issue_go && op inside {7'o42, 7'o43} |=> a_wb.valid && !issue_go
		&& a_wb.data == {$past(issue_in.next1), $past(issue_in.next2)} ##1 !issue_go) else $error("bad 32 bit load");
	a_scalar_low: assert property (issue_go && op inside {7'o50, 7'o51} |=> s_wb.valid
		&& s_wb.data == {{32{$past(op[0])}}, $past(issue_in.next1), $past(issue_in.next2)}) else $error("bad low half");
	a_scalar_high: assert property (go_op(7'o52) |=> s_wb.valid
		&& s_wb.data == {$past(issue_in.next1), $past(issue_in.next2), 32'h0000_0000}) else $error("bad high half");
	a_lm_sext: assert property (lm_wb.valid |-> lm_wb.data[63:32] == {32{lm_wb.data[31]}})
		else $error("store not sign extended");
	a_dir_addr: assert property (go_op(7'o45) |=> lm_wb.valid && !issue_go
		&& lm_wb.addr == $past(issue_in.next1[9:0])) else $error("bad direct address");
	// Parcels must already sit in the queue when the head issues
	a_parcels_in: assert property (issue_go |-> issue_in.valid && issue_len != 2'd0
		&& {1'b0, issue_in.follow_cnt} + 3'd1 >= {1'b0, issue_len}) else $error("issued without parcels");
endmodule : ilx_exec_properties

bind ilx_exec ilx_exec_properties u_ilx_exec_properties (.ref_clk, .reset, .issue_in, .issue_go, .issue_len,
	.cm_read_range_err, .cm_write_range_err, .a_wb, .s_wb, .lm_wb, .status_word);

// [ilx_queue_model.sv]
`timescale 1ns/1ps
module ilx_queue_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic issue_go,
	input wire logic [1:0] issue_len,
	output ilx_pkg::ilx_issue_t issue_in,
	output logic pending
);
	logic [15:0] feed[$];
	logic [15:0] q[$];
	logic [7:0] tick = 8'h00;
	initial issue_in = '0;
	initial pending = 1'b0;
	////////////////////////////////////////
	// Empty slots show a changing pattern so stale parcels never look valid
	function automatic logic [15:0] at(input int n);
		return (n < q.size()) ? q[n] : {tick, ~tick};
	endfunction : at
	task automatic push(input logic [15:0] p);
		feed.push_back(p);
	endtask : push
	// Pop what was consumed; slow mode lets one parcel arrive per cycle
	always @(posedge ref_clk) begin
		tick <= tick + 8'h01;
		if (issue_go === 1'b1) for (int n = 0; n < issue_len; n++) q.delete(0);
		if (slow && feed.size() > 0) q.push_back(feed.pop_front());
		if (!slow) q = {q, feed};
		if (!slow) feed.delete();
		issue_in <= '{valid: !reset && q.size() > 0, parcel: at(0), next1: at(1), next2: at(2),
			follow_cnt: (q.size() > 3) ? 2'd3 : 2'(q.size() - 1)};
		pending <= (feed.size() + q.size()) > 0;
	end
endmodule : ilx_queue_model

// [ilx_exec_tb_top.sv]
`timescale 1ns/1ps
`include "ilx_map.svh"
module ilx_exec_tb_top;
	logic ref_clk = 1'b0, reset = 1'b1, slow = 1'b0, cm_rd = 1'b0, cm_wr = 1'b0, fp = 1'b0;
	logic awv = 1'b0, wv = 1'b0, arv = 1'b0, bready = 1'b0, rready = 1'b0, pending, awr, wr, arr, bv, rv, go, fo;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, status_word, rs = 32'h0000_7aef;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] br, rr, len;
	logic [31:0] am[8] = '{default: 32'h0};
	logic [63:0] lm[1024];
	logic [6:0] ops[7] = '{7'o40, 7'o41, 7'o42, 7'o43, 7'o50, 7'o51, 7'o52};
	logic [18:13] st = 6'h00;
	logic [34:0] ea[$];
	logic [66:0] es[$];
	logic [73:0] el[$];
	int fail_count = 0, check_count = 0, n_ins = 0;
	ilx_pkg::ilx_issue_t issue_in;
	ilx_pkg::ilx_awb_t a_wb;
	ilx_pkg::ilx_swb_t s_wb;
	ilx_pkg::ilx_lmwb_t lm_wb;

	ilx_exec u_ilx_exec (.ref_clk, .reset, .issue_in, .issue_go(go), .issue_len(len), .op_foreign(fo),
		.cm_read_range_err(cm_rd), .cm_write_range_err(cm_wr), .float_range_err(fp), .a_wb, .s_wb, .lm_wb,
		.status_word, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready));
	ilx_queue_model u_ilx_queue_model (.ref_clk, .reset, .slow, .issue_go(go), .issue_len(len), .issue_in, .pending);

	// Half period of the 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	////////////////////////////////////////
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : xs
	task automatic chk(input logic [127:0] g, e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// Bus master: address and data offered together, each released once taken
	task automatic axw(input logic [31:0] a, d);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		fork
			begin @(posedge ref_clk iff awr); awv <= 1'b0; end
			begin @(posedge ref_clk iff wr); wv <= 1'b0; end
		join
		@(posedge ref_clk iff bv);
		bready <= 1'b0;
		chk(br, `AXI_OKAY);
	endtask : axw
	task automatic axr(input logic [31:0] a, output logic [33:0] d);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		@(posedge ref_clk iff arr);
		arv <= 1'b0;
		@(posedge ref_clk iff rv);
		d = {rr, rdata};
		rready <= 1'b0;
	endtask : axr
	task automatic drain();
		repeat (2) @(posedge ref_clk);
		for (int n = 0; n < 500 && pending !== 1'b0; n++) @(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
	endtask : drain
	task automatic wa(input logic [2:0] i, input logic [31:0] d);
		am[i] = d;
		ea.push_back({i, d});
	endtask : wa
	task automatic wl(input logic [9:0] a, input logic [31:0] d);
		lm[a] = {{32{d[31]}}, d};
		el.push_back({a, lm[a]});
	endtask : wl
	// Queue one instruction and predict its effect in program order
	task automatic ins(input logic [6:0] op, input logic [2:0] i, j, k, input logic [31:0] v);
		logic [9:0] a;
		a = am[k][9:0];
		n_ins++;
		u_ilx_queue_model.push({op, i, j, k});
		if (op inside {7'o42, 7'o43, 7'o50, 7'o51, 7'o52}) u_ilx_queue_model.push(v[31:16]);
		if (op inside {7'o40, 7'o41, 7'o42, 7'o43, 7'o44, 7'o45, 7'o50, 7'o51, 7'o52}) u_ilx_queue_model.push(v[15:0]);
		case (op)
			7'o37: begin
				if (k == 3'd0) st[15] = 1'b0;
				if (k == 3'd1) st[15:13] = 3'b100;
				if (k[2:1] == 2'b01) st[18] = k[0];
			end
			7'o40, 7'o41: wa(i, {{16{op[0]}}, v[15:0]});
			7'o42, 7'o43: wa(i, v);
			7'o44: wa(i, lm[v[9:0]][31:0]);
			7'o45: wl(v[9:0], am[j]);
			7'o46: wa(i, lm[a][31:0]);
			7'o47: wl(a, am[j]);
			7'o50, 7'o51: es.push_back({i, {32{op[0]}}, v});
			default: es.push_back({i, v, 32'h0000_0000});
		endcase
	endtask : ins

	// Each result pulse meets the next predicted one of its kind
	always @(posedge ref_clk) begin
		if (a_wb.valid === 1'b1) chk({a_wb.idx, a_wb.data}, ea.pop_front());
		if (s_wb.valid === 1'b1) chk({s_wb.idx, s_wb.data}, es.pop_front());
		if (lm_wb.valid === 1'b1) chk({lm_wb.addr, lm_wb.data}, el.pop_front());
	end

	initial begin
		logic [33:0] d;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		// Errors land with every enable still clear
		{cm_rd, cm_wr, fp} <= 3'b111;
		@(posedge ref_clk);
		{cm_rd, cm_wr, fp} <= 3'b000;
		st = 6'h0b;
		repeat (2) @(posedge ref_clk);
		chk(status_word, {13'h0000, st, 13'h0000});
		for (int n = 0; n < 4; n++) begin
			drain();
			ins(7'o37, 3'd0, 3'd0, n[2:0], 32'h0);
			drain();
			chk(status_word, {13'h0000, st, 13'h0000});
		end
		// Fresh memory errors, then software clears all three flags
		{cm_rd, cm_wr} <= 2'b11;
		@(posedge ref_clk);
		{cm_rd, cm_wr} <= 2'b00;
		axw(`REG_STATUS, 32'h0001_6000);
		st = 6'h24;
		axr(`REG_STATUS, d);
		chk(d, {`AXI_OKAY, 13'h0000, st, 13'h0000});
		// Held issue must not move until released
		axw(`REG_CTRL, 32'h0000_0001);
		ins(7'o40, 3'd6, 3'd0, 3'd0, 32'h0000_8001);
		repeat (8) @(posedge ref_clk);
		axr(`REG_ISSUE_CNT, d);
		chk(d[31:0], n_ins - 1);
		axw(`REG_CTRL, 32'h0);
		drain();
		axr(`REG_ISSUE_CNT, d);
		chk(d[31:0], n_ins);
		// Back-to-back loads, then local memory traffic, prompt then slow parcels
		for (int m = 0; m < 2; m++) begin
			slow <= m[0];
			for (int n = 0; n < 7; n++) ins(ops[n], 3'(xs()), 3'd0, 3'd0, xs());
			d = {2'b00, xs()};
			ins(7'o45, 3'd0, 3'd1, 3'd0, d[31:0]);
			ins(7'o44, 3'd2, 3'd0, 3'd0, d[31:0]);
			ins(7'o47, 3'd0, 3'd3, 3'd4, 32'h0);
			ins(7'o46, 3'd5, 3'd0, 3'd4, 32'h0);
			drain();
		end
		axr(32'h0000_0010, d);
		chk(d, {`AXI_DECERR, 32'h0});
		// Foreign opcode is flagged and never issued
		u_ilx_queue_model.push(16'o060000);
		repeat (3) @(posedge ref_clk);
		chk(fo, 1'b1);
		axr(`REG_ISSUE_CNT, d);
		chk(d[31:0], n_ins);
		chk(ea.size() + es.size() + el.size(), 0);
		tally_and_finish();
	end

	// Whole sequence needs a few hundred cycles; far beyond that means a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		tally_and_finish();
	end
endmodule : ilx_exec_tb_top
